// File: snf_spi_front_end.sv
// Purpose: SPI slave front end of a serial NAND with cache and data registers.
// Assumes: Link pins are asynchronous; array sequencer shares the clock.
// Notes: Link clock is oversampled, so it must stay below a quarter of clock.
`timescale 1ns/10ps
module snf_spi_front_end
    import snf_pkg::*;
(
    input wire logic clock, // 10 MHz system clock
    input wire logic nrst, // Async reset, low
    input wire logic cs_n_pin, // Chip select, low
    input wire logic sck_pin, // Serial clock
    input wire logic si_pin, // Serial input, lane 0
    input wire logic wp_n_pin, // Write protect, low
    input wire logic pause_n_pin, // Pause, low
    input wire logic pause_enable, // Pause function enable
    input wire logic array_done, // Array operation finished, pulse
    input wire logic array_fail, // Outcome with array_done
    input wire logic [COL_W-1:0] array_idx, // Data register byte index
    input wire logic [7:0] array_rdata, // Byte from array
    input wire logic array_we, // Write array_rdata to data register
    output logic so_out, // Serial output, lane 1
    output logic so_oe, // Serial output enable
    output logic [3:0] io_dir, // Lane directions, 1 is output
    output logic active_mode, // Active power state
    output logic standby, // Standby state
    output logic array_start, // Start array operation, pulse
    output snf_op_e array_op, // Array operation kind
    output logic [23:0] array_row, // Row address for array
    output logic [7:0] array_wdata, // Data register byte at array_idx
    output logic [7:0] status_out, // Status register
    output logic [7:0] protect_out // Protection register
);
    logic [4:0] sync_q;
    logic cs_s, sck_s, si_s, wp_n_s, pause_n_s;
    logic cs_d_r, sck_d_r, armed_r, frame_r, paused_r;
    logic [2:0] bit_cnt_r, byte_cnt_r, out_cnt_r;
    logic [7:0] sh_r, opc_r, feat_data_r, out_sh_r, prot_r;
    logic [23:0] addr_r;
    logic [11:0] col_r, cp_r;
    logic out_en_r, wel_r, efail_r, pfail_r;
    snf_eng_e eng_r;
    logic [7:0] cache_m [PAGE_BYTES];
    logic [7:0] dreg_m [PAGE_BYTES];

    snf_sync2 #(.W(5)) u_sync (
        .clock(clock),
        .nrst(nrst),
        .d({cs_n_pin, sck_pin, si_pin, wp_n_pin, pause_n_pin}),
        .q(sync_q)
    );
    assign {cs_s, sck_s, si_s, wp_n_s, pause_n_s} = sync_q;

    // Edge decode; reset value of cs_d_r hides a select held across reset
    wire cs_fall = cs_d_r & ~cs_s;
    wire cs_rise = ~cs_d_r & cs_s;
    wire en = frame_r & ~cs_s & ~paused_r;
    wire sck_rise = en & sck_s & ~sck_d_r;
    wire sck_fall = en & ~sck_s & sck_d_r;
    wire byte_done = sck_rise & (bit_cnt_r == 3'h7);
    wire [7:0] new_byte = {sh_r[6:0], si_s};
    wire busy = eng_r != ENG_IDLE;

    wire is_row = (opc_r == OPC_PAGE_READ) | (opc_r == OPC_PROG_EXEC) | (opc_r == OPC_ERASE);
    wire is_load = (opc_r == OPC_LOAD) | (opc_r == OPC_LOAD_RANDOM);
    wire is_col = is_load | (opc_r == OPC_READ_CACHE);
    wire is_feat = (opc_r == OPC_GET_FEAT) | (opc_r == OPC_SET_FEAT);
    wire [2:0] addr_len = is_row ? ALEN_ROW : is_col ? ALEN_COL : is_feat ? ALEN_FEAT : ALEN_NONE;
    wire last_addr = byte_cnt_r != 3'h0 && byte_cnt_r == addr_len;
    wire in_data = byte_cnt_r > addr_len;
    wire is_rd_out = (opc_r == OPC_READ_CACHE) | (opc_r == OPC_GET_FEAT);
    wire col_ok = col_r <= COL_LAST;
    wire cmd_ok = frame_r & (bit_cnt_r == 3'h0) & in_data;
    wire commit = cs_rise & cmd_ok & ~busy & armed_r;
    wire host_we = byte_done & in_data & is_load & col_ok & ~busy;

    wire [7:0] status_v = {4'h0, pfail_r, efail_r, wel_r, busy};
    wire [7:0] feat_v = (addr_r[7:0] == FEAT_STATUS) ? status_v :
                        (addr_r[7:0] == FEAT_PROTECT) ? prot_r : 8'h00;
    wire [7:0] out_byte = (opc_r == OPC_GET_FEAT) ? feat_v : col_ok ? cache_m[col_r] : 8'h00;
    wire prot_lock = ~wp_n_s & prot_r[PROT_WD_BIT];
    wire [7:0] prot_keep = {feat_data_r[7], prot_r[6:2], feat_data_r[1:0]};
    wire [7:0] prot_nxt = prot_lock ? prot_keep : feat_data_r;
    wire prot_wr = commit & (opc_r == OPC_SET_FEAT) & (addr_r[7:0] == FEAT_PROTECT);

    wire to_cache = eng_r == ENG_TO_CACHE;
    wire to_data = eng_r == ENG_TO_DATA;
    wire cache_we = to_cache | host_we;
    wire [11:0] cache_wa = to_cache ? cp_r : col_r;
    wire [7:0] cache_wd = to_cache ? dreg_m[cp_r] : new_byte;
    wire dreg_we = to_data | array_we;
    wire [11:0] dreg_wa = to_data ? cp_r : array_idx;
    wire [7:0] dreg_wd = to_data ? cache_m[cp_r] : array_rdata;

    // Selection tracking and pause, pause only moves while the link clock is low or the chip is deselected
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cs_d_r <= 1'b0;
            sck_d_r <= 1'b0;
            armed_r <= 1'b0;
            frame_r <= 1'b0;
            paused_r <= 1'b0;
            active_mode <= 1'b0;
        end else begin
            cs_d_r <= cs_s;
            sck_d_r <= sck_s;
            active_mode <= ~cs_s;
            if (cs_fall) begin
                armed_r <= 1'b1;
                frame_r <= 1'b1;
            end else if (cs_rise) begin
                frame_r <= 1'b0;
            end
            if (cs_s) begin
                paused_r <= 1'b0;
            end else if (!sck_s) begin
                paused_r <= pause_enable & ~pause_n_s;
            end
        end
    end

    // Shift in on rising edges, MSB first; idle level of the clock is irrelevant
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= 3'h0;
            sh_r <= 8'h00;
            opc_r <= 8'h00;
            addr_r <= 24'h000000;
            feat_data_r <= 8'h00;
        end else if (cs_fall) begin
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            sh_r <= new_byte;
            if (byte_done) begin
                if (byte_cnt_r != 3'h7) begin
                    byte_cnt_r <= byte_cnt_r + 3'h1;
                end
                if (byte_cnt_r == 3'h0) begin
                    opc_r <= new_byte;
                end else if (!in_data) begin
                    addr_r <= {addr_r[15:0], new_byte};
                end else if (byte_cnt_r == addr_len + 3'h1) begin
                    feat_data_r <= new_byte;
                end
            end
        end
    end

    // Column pointer and output shifter; output moves only on falling edges
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            col_r <= 12'h000;
            out_en_r <= 1'b0;
            out_cnt_r <= 3'h0;
            out_sh_r <= 8'h00;
            so_out <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            so_oe <= ~cs_s & frame_r & ~paused_r & out_en_r;
            if (cs_fall) begin
                out_en_r <= 1'b0;
                out_cnt_r <= 3'h0;
            end else if (byte_done & last_addr) begin
                out_en_r <= is_rd_out;
                if (is_col) begin
                    col_r <= {addr_r[3:0], new_byte};
                end
            end else if (host_we) begin
                col_r <= col_r + 12'h001;
            end else if (sck_fall & out_en_r) begin
                out_cnt_r <= out_cnt_r + 3'h1;
                if (out_cnt_r == 3'h0) begin
                    so_out <= out_byte[7];
                    out_sh_r <= {out_byte[6:0], 1'b0};
                    if (opc_r == OPC_READ_CACHE) begin
                        col_r <= col_r + 12'h001;
                    end
                end else begin
                    so_out <= out_sh_r[7];
                    out_sh_r <= {out_sh_r[6:0], 1'b0};
                end
            end
        end
    end

    // Page engine: array data always passes both registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            eng_r <= ENG_IDLE;
            cp_r <= 12'h000;
            wel_r <= 1'b0;
            efail_r <= 1'b0;
            pfail_r <= 1'b0;
            prot_r <= PROT_RESET;
            array_start <= 1'b0;
            array_op <= OP_NONE;
            array_row <= 24'h000000;
            standby <= 1'b1;
            io_dir <= IO_DIR_RESET;
        end else begin
            array_start <= 1'b0;
            standby <= ~busy;
            io_dir <= IO_DIR_RESET;
            if (prot_wr) begin
                prot_r <= prot_nxt;
            end
            case (eng_r)
                ENG_IDLE: begin
                    cp_r <= 12'h000;
                    if (commit) begin
                        case (opc_r)
                            OPC_WR_EN: wel_r <= 1'b1;
                            OPC_WR_DIS: wel_r <= 1'b0;
                            OPC_PAGE_READ: begin
                                eng_r <= ENG_WAIT;
                                array_start <= 1'b1;
                                array_op <= OP_READ;
                                array_row <= addr_r;
                            end
                            OPC_PROG_EXEC: begin
                                if (wel_r) begin
                                    eng_r <= ENG_TO_DATA;
                                    array_op <= OP_PROG;
                                    array_row <= addr_r;
                                end
                            end
                            OPC_ERASE: begin
                                if (wel_r) begin
                                    eng_r <= ENG_WAIT;
                                    array_start <= 1'b1;
                                    array_op <= OP_ERASE;
                                    array_row <= {addr_r[23:PAGE_BITS], 6'h00};
                                    efail_r <= 1'b0;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
                ENG_TO_DATA: begin
                    cp_r <= cp_r + 12'h001;
                    if (cp_r == COL_LAST) begin
                        eng_r <= ENG_WAIT;
                        array_start <= 1'b1;
                        pfail_r <= 1'b0;
                    end
                end
                ENG_WAIT: begin
                    if (array_done) begin
                        eng_r <= (array_op == OP_READ) ? ENG_TO_CACHE : ENG_IDLE;
                        if (array_op != OP_READ) begin
                            wel_r <= 1'b0;
                        end
                        if (array_op == OP_PROG) begin
                            pfail_r <= array_fail;
                        end
                        if (array_op == OP_ERASE) begin
                            efail_r <= array_fail;
                        end
                    end
                end
                ENG_TO_CACHE: begin
                    cp_r <= cp_r + 12'h001;
                    if (cp_r == COL_LAST) begin
                        eng_r <= ENG_IDLE;
                    end
                end
                default: eng_r <= ENG_IDLE;
            endcase
        end
    end

    // Page storage is plain flops without reset; contents are data, not control
    always_ff @(posedge clock) begin
        if (cache_we) begin
            cache_m[cache_wa] <= cache_wd;
        end
        if (dreg_we) begin
            dreg_m[dreg_wa] <= dreg_wd;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            array_wdata <= 8'h00;
            status_out <= 8'h00;
            protect_out <= PROT_RESET;
        end else begin
            array_wdata <= (array_idx <= COL_LAST) ? dreg_m[array_idx] : 8'h00;
            status_out <= status_v;
            protect_out <= prot_r;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_copy_last;
        eng_r == ENG_TO_CACHE && cp_r == COL_LAST;
    endsequence
    sequence s_back_idle;
        eng_r == ENG_IDLE ##1 standby;
    endsequence

    property p_sel_active;
        !cs_s |=> active_mode;
    endproperty
    a_sel_active: assert property (p_sel_active) else $error("not active while selected");
    property p_desel_hiz;
        cs_s |=> !so_oe;
    endproperty
    a_desel_hiz: assert property (p_desel_hiz) else $error("output driven while deselected");
    property p_armed;
        !armed_r |-> !commit && !frame_r;
    endproperty
    a_armed: assert property (p_armed) else $error("command before first select edge");
    property p_standby;
        array_start |=> !standby;
    endproperty
    a_standby: assert property (p_standby) else $error("standby while operation runs");
    property p_partial;
        cs_rise && !cmd_ok && eng_r == ENG_IDLE |=> eng_r == ENG_IDLE && $stable(wel_r);
    endproperty
    a_partial: assert property (p_partial) else $error("partial command acted on");
    property p_read_commit;
        commit && opc_r == OPC_PAGE_READ |=> array_start && array_op == OP_READ;
    endproperty
    a_read_commit: assert property (p_read_commit) else $error("page read not started");
    property p_so_fall;
        $changed(so_out) |-> $past(sck_fall);
    endproperty
    a_so_fall: assert property (p_so_fall) else $error("output moved off falling edge");
    property p_lock;
        prot_wr && prot_lock |=> prot_r[6:2] == $past(prot_r[6:2]);
    endproperty
    a_lock: assert property (p_lock) else $error("locked protect bits changed");
    property p_erase_block;
        array_start && array_op == OP_ERASE |-> array_row[PAGE_BITS-1:0] == 6'h00;
    endproperty
    a_erase_block: assert property (p_erase_block) else $error("erase not block aligned");
    property p_copy_end;
        s_copy_last |=> s_back_idle;
    endproperty
    a_copy_end: assert property (p_copy_end) else $error("cache copy did not end");
    property p_pause;
        paused_r |=> !so_oe ##1 (!so_oe || !$past(paused_r));
    endproperty
    a_pause: assert property (p_pause) else $error("output driven in pause");
endmodule

// File: snf_pkg.sv
// Purpose: Shared constants for the serial NAND front end.
// Assumes: Single-lane SPI, 10 MHz system clock sampling the link.
// Notes: Opcodes and feature addresses are fixed for this block.
package snf_pkg;
    localparam int PAGE_BYTES = 2176;
    localparam int DATA_BYTES = 2048;
    localparam int SPARE_BYTES = 128;
    localparam int PAGE_BITS = 6;
    localparam int COL_W = 12;
    localparam logic [11:0] COL_LAST = 12'h87F;
    localparam logic [7:0] OPC_WR_EN = 8'h06;
    localparam logic [7:0] OPC_WR_DIS = 8'h04;
    localparam logic [7:0] OPC_GET_FEAT = 8'h0F;
    localparam logic [7:0] OPC_SET_FEAT = 8'h1F;
    localparam logic [7:0] OPC_PAGE_READ = 8'h13;
    localparam logic [7:0] OPC_READ_CACHE = 8'h03;
    localparam logic [7:0] OPC_LOAD = 8'h02;
    localparam logic [7:0] OPC_LOAD_RANDOM = 8'h84;
    localparam logic [7:0] OPC_PROG_EXEC = 8'h10;
    localparam logic [7:0] OPC_ERASE = 8'hD8;
    localparam logic [7:0] FEAT_PROTECT = 8'hA0;
    localparam logic [7:0] FEAT_STATUS = 8'hC0;
    localparam int PROT_WD_BIT = 7;
    localparam int PROT_BP_LSB = 3;
    localparam int PROT_TB_BIT = 2;
    localparam logic [7:0] PROT_RESET = 8'h00;
    localparam logic [3:0] IO_DIR_RESET = 4'hA;
    localparam logic [2:0] ALEN_ROW = 3'h3;
    localparam logic [2:0] ALEN_COL = 3'h2;
    localparam logic [2:0] ALEN_FEAT = 3'h1;
    localparam logic [2:0] ALEN_NONE = 3'h0;
    typedef enum logic [1:0] {OP_NONE, OP_READ, OP_PROG, OP_ERASE} snf_op_e;
    typedef enum logic [1:0] {ENG_IDLE, ENG_WAIT, ENG_TO_CACHE, ENG_TO_DATA} snf_eng_e;
endpackage

// File: snf_sync2.sv
// Purpose: Two-flop synchroniser for pins entering the clock domain.
// Assumes: Inputs are independent levels.
// Notes: Only the second stage is visible outside.
`timescale 1ns/10ps
module snf_sync2 #(
    parameter int W = 1
) (
    input wire logic clock, // System clock
    input wire logic nrst, // Async reset, low
    input wire logic [W-1:0] d, // Raw pins
    output logic [W-1:0] q // Synchronised levels
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// File: snf_host_model.sv
// Purpose: Host SPI master model facing the serial NAND front end.
// Assumes: Clock period 100 ns; link half period of four clocks (400 ns).
// Notes: Pins change just after clock falling edges; so is read at each sck rise.
`timescale 1ns/10ps
module snf_host_model (
    input wire logic clock, // System clock
    input wire logic so_out, // Device serial output
    input wire logic so_oe, // Device output enable
    output logic cs_n, // Chip select, low
    output logic sck, // Link clock
    output logic si // Serial data to device
);
    logic mode3;
    logic so_last;
    initial begin
        mode3 = 1'b0;
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        so_last = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic set_mode(input logic m3);
        mode3 = m3;
        sck = m3;
        wait_clk(4);
    endtask
    task automatic start();
        wait_clk(6);
        cs_n = 1'b0;
        wait_clk(4);
    endtask
    task automatic sck_low();
        sck = 1'b0;
        wait_clk(4);
    endtask
    // A floating output reads as the inverse of the last bit, so a floating byte reads as alternating bits
    task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sck = 1'b0;
            si = tx[i];
            wait_clk(4);
            so_last = so_oe ? so_out : ~so_last;
            rx[i] = so_last;
            sck = 1'b1;
            wait_clk(4);
        end
    endtask
    task automatic stop();
        sck = mode3;
        wait_clk(4);
        cs_n = 1'b1;
        si = ~si;
    endtask
endmodule

// File: serial_nand_spi_front_end_bench.sv
// Purpose: Self-checking bench for the serial NAND front end.
// Assumes: Host model drives the link; the bench plays the array sequencer.
// Notes: Frames run in mode 0 and mode 3; seed fixed for repeatable runs.
`timescale 1ns/10ps
module serial_nand_spi_front_end_bench;
    import snf_pkg::*;
    logic clock, nrst, wp_n, pause_n, pause_en, array_done, array_fail, array_we;
    logic cs_n, sck, si, so_out, so_oe, active_mode, standby, array_start;
    logic [COL_W-1:0] array_idx, col;
    logic [7:0] array_rdata, array_wdata, status_out, protect_out, rx, prot, d;
    logic [3:0] io_dir;
    logic [23:0] array_row, row;
    snf_op_e array_op;
    logic [7:0] page [PAGE_BYTES];
    int err_count = 0;
    int num_checks = 0;
    int starts = 0;
    int n0;
    snf_host_model host (.clock(clock), .so_out(so_out), .so_oe(so_oe), .cs_n(cs_n),
        .sck(sck), .si(si));
    snf_spi_front_end dut (.clock(clock), .nrst(nrst), .cs_n_pin(cs_n), .sck_pin(sck),
        .si_pin(si), .wp_n_pin(wp_n), .pause_n_pin(pause_n), .pause_enable(pause_en),
        .array_done(array_done), .array_fail(array_fail), .array_idx(array_idx),
        .array_rdata(array_rdata), .array_we(array_we), .so_out(so_out), .so_oe(so_oe),
        .io_dir(io_dir), .active_mode(active_mode), .standby(standby),
        .array_start(array_start), .array_op(array_op), .array_row(array_row),
        .array_wdata(array_wdata), .status_out(status_out), .protect_out(protect_out));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) if (array_start === 1'b1) starts++;
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic end_sim();
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] exp_byte(input int c);
        return (c < PAGE_BYTES) ? page[c] : 8'h00;
    endfunction
    task automatic put(input int n, input logic [31:0] w);
        for (int k = n - 1; k >= 0; k--) host.bits(w[8*k +: 8], 8, rx);
    endtask
    task automatic frame(input int n, input logic [31:0] w);
        host.start();
        put(n, w);
        host.stop();
        host.wait_clk(8);
    endtask
    task automatic get_feat(input logic [7:0] a, input logic [7:0] exp);
        host.start();
        put(2, {16'h0, OPC_GET_FEAT, a});
        host.bits(8'h00, 8, rx);
        host.stop();
        check(rx, exp, "feature read");
    endtask
    task automatic wait_for(input logic idle, input int lim);
        int t;
        t = 0;
        while ((idle ? standby : array_start) !== 1'b1 && t < lim) begin
            @(negedge clock);
            t++;
        end
        check(8'(t < lim), 8'h01, "wait bound");
    endtask
    task automatic pulse_done(input logic f);
        array_fail = f;
        array_done = 1'b1;
        @(negedge clock);
        array_done = 1'b0;
    endtask
    initial begin
        #(60000 * 100);
        err_count++;
        end_sim();
    end
    initial begin
        nrst = 1'b0;
        wp_n = 1'b1;
        pause_n = 1'b1;
        pause_en = 1'b0;
        array_done = 1'b0;
        array_fail = 1'b0;
        array_idx = '0;
        array_rdata = 8'h00;
        array_we = 1'b0;
        n0 = $urandom(32'h6E07);
        host.start();
        check({io_dir, 2'b00, so_oe, standby}, 8'hA1, "reset pins");
        check(status_out | protect_out | 8'(active_mode), 8'h00, "reset regs");
        nrst = 1'b1;
        put(1, {24'h0, OPC_WR_EN});
        host.stop();
        host.wait_clk(8);
        check(status_out, 8'h00, "cmd before cs fall");
        for (int m = 0; m < 2; m++) begin
            host.set_mode(m[0]);
            host.start();
            put(1, {24'h0, OPC_WR_EN});
            check(8'(active_mode), 8'h01, "active");
            check(status_out, 8'h00, "early commit");
            host.stop();
            host.wait_clk(8);
            check(8'({active_mode, so_oe}), 8'h00, "deselect");
            get_feat(FEAT_STATUS, 8'h02);
            frame(1, {24'h0, OPC_WR_DIS});
            get_feat(FEAT_STATUS, 8'h00);
        end
        host.start();
        host.bits(OPC_WR_EN, 5, rx);
        host.stop();
        host.start();
        host.bits(OPC_WR_EN, 8, rx);
        host.bits(8'h00, 3, rx);
        host.stop();
        get_feat(FEAT_STATUS, 8'h00);
        // Lock needs write-disable set first, so the protect pin level must not matter yet
        wp_n = 1'($urandom());
        prot = 8'($urandom()) & 8'h7F;
        frame(3, {8'h0, OPC_SET_FEAT, FEAT_PROTECT, prot});
        check(protect_out, prot, "unlocked write");
        prot = 8'($urandom()) | 8'h80;
        frame(3, {8'h0, OPC_SET_FEAT, FEAT_PROTECT, prot});
        wp_n = 1'b0;
        d = 8'($urandom());
        frame(3, {8'h0, OPC_SET_FEAT, FEAT_PROTECT, d});
        prot = {d[7], prot[6:2], d[1:0]};
        get_feat(FEAT_PROTECT, prot);
        wp_n = 1'b1;
        prot = 8'($urandom()) & 8'h7F;
        frame(3, {8'h0, OPC_SET_FEAT, FEAT_PROTECT, prot});
        check(protect_out, prot, "unlock");
        pause_en = 1'b1;
        host.start();
        put(2, {16'h0, OPC_GET_FEAT, FEAT_PROTECT});
        host.sck_low();
        pause_n = 1'b0;
        host.wait_clk(8);
        check(8'(so_oe), 8'h00, "pause float");
        pause_n = 1'b1;
        host.wait_clk(8);
        host.bits(8'h00, 8, rx);
        host.stop();
        check(rx, prot, "read after pause");
        pause_en = 1'b0;
        // With the function disabled the pause pin must be ignored
        pause_n = 1'($urandom());
        row = 24'($urandom());
        host.start();
        put(4, {OPC_PAGE_READ, row});
        host.stop();
        wait_for(1'b0, 20);
        check(8'(array_op === OP_READ && array_row === row), 8'h01, "page read");
        for (int i = 0; i < PAGE_BYTES; i++) begin
            page[i] = 8'($urandom());
            array_idx = 12'(i);
            array_rdata = page[i];
            array_we = 1'b1;
            @(negedge clock);
        end
        array_we = 1'b0;
        pulse_done(1'b0);
        wait_for(1'b1, 3000);
        for (int r = 0; r < 2; r++) begin
            col = (r == 1) ? 12'h87E : 12'($urandom_range(2175));
            host.start();
            put(3, {8'h0, OPC_READ_CACHE, 4'h0, col});
            for (int k = 0; k < 4; k++) begin
                host.bits(8'h00, 8, rx);
                check(rx, exp_byte(int'(col) + k), "cache read");
            end
            host.stop();
        end
        frame(1, {24'h0, OPC_WR_EN});
        col = 12'($urandom_range(2000));
        d = 8'($urandom());
        frame(4, {OPC_LOAD_RANDOM, 4'h0, col, d});
        host.start();
        put(4, {OPC_PROG_EXEC, row});
        host.stop();
        wait_for(1'b0, 2400);
        check(8'(array_op === OP_PROG), 8'h01, "prog op");
        check(8'({standby, status_out[0]}), 8'h01, "busy");
        get_feat(FEAT_STATUS, 8'h03);
        for (int k = 0; k < 2; k++) begin
            array_idx = col + 12'(k);
            host.wait_clk(2);
            check(array_wdata, (k == 1) ? page[col + 1] : d, "data reg");
        end
        pulse_done(1'b1);
        wait_for(1'b1, 20);
        get_feat(FEAT_STATUS, 8'h08);
        n0 = starts;
        frame(4, {OPC_ERASE, row});
        check(8'(starts - n0), 8'h00, "erase without enable");
        frame(1, {24'h0, OPC_WR_EN});
        host.start();
        put(4, {OPC_ERASE, row});
        host.stop();
        wait_for(1'b0, 20);
        check(8'(array_op === OP_ERASE && array_row === {row[23:6], 6'h00}), 8'h01,
            "erase");
        d = 8'($urandom());
        pulse_done(d[0]);
        wait_for(1'b1, 20);
        // Program failure stays flagged until the next program starts
        get_feat(FEAT_STATUS, {4'h0, 1'b1, d[0], 2'b00});
        frame(1, {24'h0, OPC_WR_EN});
        nrst = 1'b0;
        host.wait_clk(3);
        check(status_out | protect_out, 8'h00, "mid-run reset");
        nrst = 1'b1;
        get_feat(FEAT_STATUS, 8'h00);
        end_sim();
    end
endmodule
